// File: hdl/tsar_defines.vh
`ifndef TSAR_DEFINES_VH
`define TSAR_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TSAR_OFF_STATUS     12'h000
`define TSAR_OFF_RES_BASE   12'h004
`define TSAR_OFF_RES_STEP   12'h004
`define TSAR_OFF_IRQ_STAT   12'h028
`define TSAR_OFF_IRQ_MASK   12'h02C

// ----------------------------------------
// result slot indices
// ----------------------------------------
`define TSAR_NRES           9
`define TSAR_NGRP           5
`define TSAR_SLOT_XCUR      2
`define TSAR_SLOT_YCUR      5

// ----------------------------------------
// field positions
// ----------------------------------------
`define TSAR_ST_DAV_HI      15
`define TSAR_ST_DAV_LO      11
`define TSAR_ST_RST         7
`define TSAR_ST_PD          2
`define TSAR_RES_TOUCH      15
`define TSAR_RES_HI         11
`define TSAR_RES_LO10_HI    9

// ----------------------------------------
// reset values
// ----------------------------------------
`define TSAR_RESULT_RST     16'h0000
`define TSAR_PD_RST         1'b1
`define TSAR_RSTFLAG_RST    1'b0
`define TSAR_MASK_RST       5'h00
`define TSAR_STAT_RST       5'h00

`endif

// File: hdl/tsar_result_slot.v
`timescale 1ns/1ps
`include "tsar_defines.vh"

module tsar_result_slot #(
  parameter CUR_SLOT = 0                // 1 for a panel current slot
) (
  input  wire        hclk,              // clock
  input  wire        hresetn,           // async reset, low
  input  wire        clr,               // soft reset pulse
  input  wire        store,             // write this slot
  input  wire [11:0] data,              // raw result word
  input  wire        res_10bit,         // 10-bit resolution
  input  wire        touch,             // touch seen in conversion
  output reg  [15:0] value_q            // stored result
);

  // ----------------------------------------
  // formatting of the stored word
  // ----------------------------------------
  wire [11:0] fmt_w;
  wire        tbit_w;

  assign fmt_w  = res_10bit ? {2'b00, data[`TSAR_RES_LO10_HI:0]} : data;
  assign tbit_w = (CUR_SLOT != 0) ? touch : 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      value_q <= `TSAR_RESULT_RST;
    else if (clr)
      value_q <= `TSAR_RESULT_RST;
    else if (store)
      value_q <= {tbit_w, 3'h0, fmt_w};
  end

endmodule // tsar_result_slot

// File: hdl/tsar_regs.v
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tsar_defines.vh"

module tsar_regs (
  input  wire        hclk,                 // bus and conversion clock
  input  wire        hresetn,              // async reset, low
  input  wire        hsel,                 // slave select
  input  wire [31:0] haddr,                // byte address
  input  wire [1:0]  htrans,               // transfer type
  input  wire        hwrite,               // write when high
  input  wire [2:0]  hsize,                // transfer size
  input  wire [31:0] hwdata,               // write data
  input  wire        hready,               // bus ready
  output reg  [31:0] hrdata_q,             // read data
  output reg         hreadyout_q,          // slave ready
  output reg         hresp_q,              // always okay
  input  wire [8:0]  store_strobe,         // one-hot result write
  input  wire [11:0] store_data,           // result word
  input  wire        res_10bit,            // 10-bit resolution
  input  wire        store_touch,          // touch during current conv
  input  wire        soft_reset,           // software reset pulse
  input  wire        bias_powerdown_ctrl,  // control byte bias bit
  input  wire        pen_touch,            // pen touch detected pulse
  input  wire        func_start,           // converter function start
  input  wire        set_active,           // conversion set running
  input  wire        conv_phase,           // sampling or converting
  output reg         bias_powerdown_state, // power-down status
  output reg         adc_bias_on_q,        // adc bias enable
  output reg  [4:0]  new_result_flags,     // data-available per type
  output reg         irq_q                 // interrupt, high level
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [8:0]  upd_q;        // result updated, not yet read
  reg         rst_flag_q;   // status bit 7
  reg  [4:0]  irq_stat_q;   // sticky new-data events
  reg  [4:0]  irq_mask_q;   // interrupt enables
  reg         wr_pend_q;    // write data phase pending
  reg  [11:0] wr_addr_q;    // address of pending write

  wire [15:0] res_w [0:8];
  wire        acc_w;
  wire        rd_w;
  wire [11:0] addr_w;
  wire        addr_ok_w;

  reg  [8:0]  rd_res_w;
  reg         rd_status_w;
  reg         rd_irq_w;
  reg  [31:0] rdata_w;
  reg  [8:0]  upd_d;
  reg  [4:0]  dav_w;
  reg  [4:0]  dav_d;
  reg  [4:0]  ev_w;
  reg  [4:0]  irq_stat_d;
  reg  [4:0]  irq_mask_d;
  reg  [15:0] status_w;
  integer     i;

  // ----------------------------------------
  // address phase
  // ----------------------------------------
  assign acc_w     = hsel & hready & htrans[1];
  assign rd_w      = acc_w & ~hwrite;
  assign addr_w    = haddr[11:0];
  assign addr_ok_w = (haddr[31:12] == 20'h00000);

  // ----------------------------------------
  // result slots
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `TSAR_NRES; g = g + 1)
    begin : g_slot
      tsar_result_slot #(
        .CUR_SLOT ((g == `TSAR_SLOT_XCUR) || (g == `TSAR_SLOT_YCUR))
      ) u_slot (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clr       (soft_reset),
        .store     (store_strobe[g]),
        .data      (store_data),
        .res_10bit (res_10bit),
        .touch     (store_touch),
        .value_q   (res_w[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // read decode and read data
  // ----------------------------------------
  always @*
  begin
    rd_res_w    = 9'h000;
    rd_status_w = 1'b0;
    rd_irq_w    = 1'b0;
    rdata_w     = 32'h00000000;
    if (rd_w && addr_ok_w)
    begin
      if (addr_w == `TSAR_OFF_STATUS)
      begin
        rd_status_w = 1'b1;
        rdata_w     = {16'h0000, status_w};
      end
      if (addr_w == `TSAR_OFF_IRQ_STAT)
      begin
        rd_irq_w = 1'b1;
        rdata_w  = {27'h0000000, irq_stat_q};
      end
      if (addr_w == `TSAR_OFF_IRQ_MASK)
        rdata_w = {27'h0000000, irq_mask_q};
      for (i = 0; i < `TSAR_NRES; i = i + 1)
      begin
        if (addr_w == `TSAR_OFF_RES_BASE + i[11:0] * `TSAR_OFF_RES_STEP)
        begin
          rd_res_w[i] = 1'b1;
          rdata_w     = {16'h0000, res_w[i]};
        end
      end
    end
  end

  // ----------------------------------------
  // data-available tracking
  // ----------------------------------------
  always @*
  begin
    upd_d = (upd_q & ~rd_res_w) | store_strobe;
    if (soft_reset)
      upd_d = 9'h000;
    // x group: x1, x2, x current; y group likewise
    dav_w[4] = |upd_q[2:0];
    dav_w[3] = |upd_q[5:3];
    dav_w[2] = upd_q[6];
    dav_w[1] = upd_q[7];
    dav_w[0] = upd_q[8];
    dav_d[4] = |upd_d[2:0];
    dav_d[3] = |upd_d[5:3];
    dav_d[2] = upd_d[6];
    dav_d[1] = upd_d[7];
    dav_d[0] = upd_d[8];
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  always @*
  begin
    status_w = 16'h0000;
    status_w[`TSAR_ST_DAV_HI:`TSAR_ST_DAV_LO] = dav_w;
    status_w[`TSAR_ST_RST] = rst_flag_q;
    status_w[`TSAR_ST_PD]  = bias_powerdown_state;
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  always @*
  begin
    ev_w[4] = |store_strobe[2:0];
    ev_w[3] = |store_strobe[5:3];
    ev_w[2] = store_strobe[6];
    ev_w[1] = store_strobe[7];
    ev_w[0] = store_strobe[8];
    irq_stat_d = (irq_stat_q & ~{5{rd_irq_w}}) | ev_w;
    irq_mask_d = irq_mask_q;
    if (wr_pend_q && (wr_addr_q == `TSAR_OFF_IRQ_MASK))
      irq_mask_d = hwdata[4:0];
  end

  // ----------------------------------------
  // bus slave registers
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 12'h000;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      hrdata_q    <= rdata_w;
      wr_pend_q   <= acc_w & hwrite & addr_ok_w;
      if (acc_w)
        wr_addr_q <= addr_w;
    end
  end

  // ----------------------------------------
  // flags, power-down state, bias control
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      upd_q                <= 9'h000;
      new_result_flags     <= 5'h00;
      rst_flag_q           <= `TSAR_RSTFLAG_RST;
      bias_powerdown_state <= `TSAR_PD_RST;
      adc_bias_on_q        <= 1'b0;
      irq_stat_q           <= `TSAR_STAT_RST;
      irq_mask_q           <= `TSAR_MASK_RST;
      irq_q                <= 1'b0;
    end
    else
    begin
      upd_q            <= upd_d;
      new_result_flags <= dav_d;
      irq_stat_q       <= irq_stat_d;
      irq_mask_q       <= irq_mask_d;
      irq_q            <= |(irq_stat_d & irq_mask_d);
      if (soft_reset)
        rst_flag_q <= 1'b0;
      else if (rd_status_w)
        rst_flag_q <= 1'b1;
      if (soft_reset)
        bias_powerdown_state <= `TSAR_PD_RST;
      else if (pen_touch || func_start)
        bias_powerdown_state <= bias_powerdown_ctrl;
      // off between sets; inside a set off between conversions if requested
      adc_bias_on_q <= set_active & (conv_phase | ~bias_powerdown_state);
    end
  end

endmodule // tsar_regs

// File: bench/tsar_conv_model.sv
`timescale 1ns/1ps
module tsar_conv_model (
  input  wire         hclk,         // clock
  output logic [8:0]  store_strobe, // one-hot store
  output logic [11:0] store_data,   // result word
  output logic        store_touch   // touch seen
);
  initial
  begin
    store_strobe = 9'h000;
    store_data   = 12'h000;
    store_touch  = 1'b0;
  end
  // one store pulse, then the data lines stop showing the old word
  task store(input int slot, input logic [11:0] d, input logic t);
    @(posedge hclk);
    store_strobe <= 9'h001 << slot;
    store_data   <= d;
    store_touch  <= t;
    @(posedge hclk);
    store_strobe <= 9'h000;
    store_data   <= ~d;
    store_touch  <= ~t;
  endtask
endmodule // tsar_conv_model

// File: bench/tsar_regs_monitor.sv
`timescale 1ns/1ps
module tsar_regs_monitor (
  input wire        hclk,                 // clock
  input wire        hresetn,              // reset, low
  input wire        hsel,                 // select
  input wire [1:0]  htrans,               // transfer
  input wire        hwrite,               // write
  input wire        hready,               // ready
  input wire [31:0] hrdata_q,             // read data
  input wire [8:0]  store_strobe,         // stores
  input wire        soft_reset,           // soft reset
  input wire        bias_powerdown_ctrl,  // pd control
  input wire        pen_touch,            // touch
  input wire        func_start,           // start
  input wire        set_active,           // set running
  input wire        conv_phase,           // converting
  input wire        bias_powerdown_state, // pd state
  input wire        adc_bias_on_q,        // bias on
  input wire [4:0]  new_result_flags      // flags
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence pd_evt;
    (pen_touch || func_start) && !soft_reset;
  endsequence
  x_flag_set_a: assert property (|store_strobe[2:0] && !soft_reset |=>
    new_result_flags[4]) else $error("x flag not set");
  y_flag_set_a: assert property (|store_strobe[5:3] && !soft_reset |=>
    new_result_flags[3]) else $error("y flag not set");
  aux_flag_set_a: assert property (store_strobe[8] && !soft_reset |=>
    new_result_flags[0]) else $error("aux flag not set");
  flag_clear_a: assert property ($fell(new_result_flags[0]) |->
    $past(hsel && htrans[1] && !hwrite) || $past(soft_reset)) else $error("flag lost");
  rd_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=>
    hrdata_q == 32'h00000000) else $error("stray read data");
  rd_upper_a: assert property (rd_take |=> hrdata_q[31:16] == 16'h0000)
    else $error("upper bits set");
  pd_load_a: assert property (pd_evt |=>
    bias_powerdown_state == $past(bias_powerdown_ctrl)) else $error("pd not loaded");
  pd_hold_a: assert property (!(pen_touch || func_start || soft_reset) |=>
    $stable(bias_powerdown_state)) else $error("pd moved");
  bias_off_a: assert property (!set_active |=> !adc_bias_on_q)
    else $error("bias on between sets");
  bias_hold_a: assert property (set_active && !conv_phase && bias_powerdown_state |=>
    !adc_bias_on_q) else $error("bias on while powered down");
endmodule // tsar_regs_monitor
bind tsar_regs tsar_regs_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata_q(hrdata_q),
  .store_strobe(store_strobe), .soft_reset(soft_reset),
  .bias_powerdown_ctrl(bias_powerdown_ctrl), .pen_touch(pen_touch), .func_start(func_start),
  .set_active(set_active), .conv_phase(conv_phase),
  .bias_powerdown_state(bias_powerdown_state), .adc_bias_on_q(adc_bias_on_q),
  .new_result_flags(new_result_flags));

// File: bench/touch_adc_status_data_regs_tb.sv
`timescale 1ns/1ps
module touch_adc_status_data_regs_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, res_10bit = 0, soft_reset = 0;
  logic ctrl = 1, pen_touch = 0, func_start = 0, set_active = 0, conv_phase = 0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_q;
  wire hready, hresp_q, pd_q, bias_q, irq_q, touch;
  wire [8:0] strobe;
  wire [11:0] sdata;
  wire [4:0] flags;
  int bad_count = 0, comparisons = 0;
  always #2 hclk = ~hclk;
  tsar_conv_model conv_u (.hclk(hclk), .store_strobe(strobe), .store_data(sdata),
    .store_touch(touch));
  tsar_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata_q(hrdata_q), .hreadyout_q(hready), .hresp_q(hresp_q), .store_strobe(strobe),
    .store_data(sdata), .res_10bit(res_10bit), .store_touch(touch), .soft_reset(soft_reset),
    .bias_powerdown_ctrl(ctrl), .pen_touch(pen_touch), .func_start(func_start),
    .set_active(set_active), .conv_phase(conv_phase), .bias_powerdown_state(pd_q),
    .adc_bias_on_q(bias_q), .new_result_flags(flags), .irq_q(irq_q));
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (hready !== 1'b1)
    begin
      $display("wrong value at %0t: bus wait timed out", $time);
      bad_count++;
      wrap_up();
    end
  endtask
  task bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata_q;
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task tick;
    repeat (2) @(posedge hclk);
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(32'h000, 32'h00000004);
    rchk(32'h000, 32'h00000084);
    for (int i = 0; i < 9; i++) rchk(32'h004 + 4 * i, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 9; i++) conv_u.store(i, 12'hA00 + i, 1'b1);
    rchk(32'h004, 32'h00000A00);
    rchk(32'h000, 32'h0000F884);
    for (int i = 1; i < 9; i++) rchk(32'h004 + 4 * i,
      32'hA00 + i + ((i == 2 || i == 5) ? 32'h8000 : 32'h0));
    rchk(32'h000, 32'h00000084);
    conv_u.store(2, 12'h123, 1'b0);
    rchk(32'h000, 32'h00008084);
    chk(flags, 32'h00000010);
    rchk(32'h004, 32'h00000A00);
    rchk(32'h00C, 32'h00000123);
    res_10bit <= 1'b1;
    conv_u.store(8, 12'hFFF, 1'b1);
    res_10bit <= 1'b0;
    rchk(32'h024, 32'h000003FF);
    $display("test results done");
    rchk(32'h028, 32'h0000001F);
    rchk(32'h028, 32'h00000000);
    wr(32'h02C, 32'h00000001);
    rchk(32'h02C, 32'h00000001);
    conv_u.store(8, 12'h001, 1'b0);
    tick();
    chk(irq_q, 1'b1);
    rchk(32'h028, 32'h00000001);
    tick();
    chk(irq_q, 1'b0);
    rchk(32'h024, 32'h00000001);
    rchk(32'h030, 32'h00000000);
    rchk(32'h00001000, 32'h00000000);
    wr(32'h000, 32'hFFFFFFFF);
    rchk(32'h000, 32'h00000084);
    $display("test bus and interrupt done");
    ctrl <= 1'b0;
    tick();
    rchk(32'h000, 32'h00000084);
    func_start <= 1'b1;
    @(posedge hclk) func_start <= 1'b0;
    rchk(32'h000, 32'h00000080);
    set_active <= 1'b1;
    tick();
    chk(bias_q, 1'b1);
    set_active <= 1'b0;
    tick();
    chk(bias_q, 1'b0);
    ctrl <= 1'b1;
    pen_touch <= 1'b1;
    @(posedge hclk) pen_touch <= 1'b0;
    set_active <= 1'b1;
    tick();
    chk(bias_q, 1'b0);
    conv_phase <= 1'b1;
    tick();
    chk(bias_q, 1'b1);
    set_active <= 1'b0;
    rchk(32'h000, 32'h00000084);
    $display("test power-down done");
    conv_u.store(0, 12'h055, 1'b0);
    soft_reset <= 1'b1;
    @(posedge hclk) soft_reset <= 1'b0;
    rchk(32'h000, 32'h00000004);
    rchk(32'h004, 32'h00000000);
    $display("test soft reset done");
    wrap_up();
  end
endmodule // touch_adc_status_data_regs_tb
